// file: src/pwm_aq_pkg.sv
// Purpose: Constants and types shared by the PWM action qualifier.
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses.
// Notes: Event index order is the bit order of the action words.
// Behaviour
// - Direction-qualified period, zero, compare A/B events
// - Two trigger events per direction from sources
// - Trigger source choice independent of trip setup
// - Up-down mode: no up-period, no down-zero
// - Up priority: force,period,t0,t1,B,A,zero
// - Down priority: force,zero,t0,t1,B,A,period
// - Compare above period never raises events
// - Count-up: period event precedes zero event
// - Count-down: zero event precedes period event
// - Per event: set, clear, toggle or hold
// - Hold-configured events still reach event outputs
// - Separate action config for outputs A, B
// - Software force acts regardless of timer events
// - One-shot force, later events change output again
// - Continuous force holds until released; selectable trigger
// - Force enabled separately per output
// - Symmetric: up compare A high, down low
// - Compares and action configs are shadowed
// - Shadow load at zero/period/sync/now or global
package pwm_aq_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMP_A = 8'h04;
    localparam logic [7:0] ADDR_CMP_B = 8'h08;
    localparam logic [7:0] ADDR_ACT_A = 8'h0C;
    localparam logic [7:0] ADDR_ACT_B = 8'h10;
    localparam logic [7:0] ADDR_TRIG_SEL = 8'h14;
    localparam logic [7:0] ADDR_FORCE = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;

    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_UPD_MODE = 0;
    localparam int CTRL_GLOBAL_UPD = 4;
    localparam int TSEL_T0 = 0;
    localparam int TSEL_T1 = 4;
    localparam int FRC_EN = 0;
    localparam int FRC_OS_LVL = 1;
    localparam int FRC_OS_GO = 3;
    localparam int FRC_CONT_LVL = 4;
    localparam int FRC_CONT_SEL = 6;
    localparam int FRC_B_BASE = 8;
    localparam int FRC_W = 16;
    localparam int ST_OUT_A = 0;
    localparam int ST_OUT_B = 1;
    localparam int ST_DIR = 2;
    localparam int ST_CONT_A = 3;
    localparam int ST_CONT_B = 4;

    // ------------------------------------------------------------
    // Events and actions
    // ------------------------------------------------------------
    localparam int NUM_EV = 6;
    localparam int ACT_W = 2;
    localparam int CFG_W = 2 * NUM_EV * ACT_W;
    localparam int EV_ZERO = 0;
    localparam int EV_PERIOD = 1;
    localparam int EV_A = 2;
    localparam int EV_B = 3;
    localparam int EV_T0 = 4;
    localparam int EV_T1 = 5;
    // Lowest to highest priority, three bits per entry from bit 0
    localparam logic [17:0] UP_ORDER = {3'h1, 3'h4, 3'h5, 3'h3, 3'h2, 3'h0};
    localparam logic [17:0] DOWN_ORDER = {3'h0, 3'h4, 3'h5, 3'h3, 3'h2, 3'h1};

    typedef enum logic [1:0] {ACT_HOLD, ACT_LOW, ACT_HIGH, ACT_TOGGLE} act_e;
    typedef enum logic [1:0] {UPD_ZERO, UPD_PERIOD, UPD_SYNC, UPD_NOW} upd_e;
    typedef enum logic [1:0] {
        CTRIG_NOW, CTRIG_ZERO, CTRIG_PERIOD, CTRIG_NOW_ALT
    } ctrig_e;

endpackage : pwm_aq_pkg

// file: src/pwm_gen_if.sv
// Purpose: Carries events, action setup and force controls to one output.
// Assumes: Same clock on both sides.
// Notes: dir high means the timer counts down.
interface pwm_gen_if;
    logic dir;
    logic [pwm_aq_pkg::NUM_EV-1:0] ev;
    logic [pwm_aq_pkg::CFG_W-1:0] cfg;
    logic force_en;
    logic [1:0] os_lvl;
    logic os_go;
    logic [1:0] cont_lvl;
    logic [1:0] cont_sel;
    logic out;
    logic cont_active;

    modport ctrl (
        output dir, ev, cfg, force_en, os_lvl, os_go, cont_lvl, cont_sel,
        input out, cont_active
    );
    modport gen (
        input dir, ev, cfg, force_en, os_lvl, os_go, cont_lvl, cont_sel,
        output out, cont_active
    );
endinterface : pwm_gen_if

// file: src/pwm_out_resolver.sv
// Purpose: Resolves events and forces into one PWM output level.
// Assumes: At most one event set per index per cycle; dir is stable.
// Notes: New level shows one edge after the causing event.
module pwm_out_resolver (
    input wire logic aclk,
    input wire logic aresetn,
    pwm_gen_if.gen g
);
    typedef struct packed {
        logic out;
        logic cont_active;
    } state_s;

    state_s s_q;
    state_s s_d;

    always_comb begin
        logic [1:0] act;
        logic [1:0] a;
        logic [2:0] idx;
        logic trig;
        int base;
        act = pwm_aq_pkg::ACT_HOLD;
        a = pwm_aq_pkg::ACT_HOLD;
        idx = 3'h0;
        trig = 1'b0;
        base = 0;
        s_d = s_q;
        // Walk from lowest to highest; later hits win
        for (int k = 0; k < pwm_aq_pkg::NUM_EV; k++) begin
            idx = g.dir ? pwm_aq_pkg::DOWN_ORDER[3*k +: 3]
                        : pwm_aq_pkg::UP_ORDER[3*k +: 3];
            base = (g.dir ? pwm_aq_pkg::NUM_EV * 2 : 0) + 2 * int'(idx);
            a = g.cfg[base +: 2];
            if (g.ev[idx] && a != pwm_aq_pkg::ACT_HOLD) begin
                act = a;
            end
        end
        unique case (act)
            pwm_aq_pkg::ACT_LOW: s_d.out = 1'b0;
            pwm_aq_pkg::ACT_HIGH: s_d.out = 1'b1;
            pwm_aq_pkg::ACT_TOGGLE: s_d.out = ~s_q.out;
            pwm_aq_pkg::ACT_HOLD: s_d.out = s_q.out;
        endcase
        // Continuous force arms on its selected trigger
        unique case (g.cont_sel)
            pwm_aq_pkg::CTRIG_ZERO: trig = g.ev[pwm_aq_pkg::EV_ZERO];
            pwm_aq_pkg::CTRIG_PERIOD: trig = g.ev[pwm_aq_pkg::EV_PERIOD];
            pwm_aq_pkg::CTRIG_NOW, pwm_aq_pkg::CTRIG_NOW_ALT: trig = 1'b1;
        endcase
        if (!g.force_en || g.cont_lvl == pwm_aq_pkg::ACT_HOLD
                || g.cont_lvl == pwm_aq_pkg::ACT_TOGGLE) begin
            s_d.cont_active = 1'b0;
        end else if (trig) begin
            s_d.cont_active = 1'b1;
        end
        // Forces rank above every timer event
        if (s_d.cont_active) begin
            s_d.out = (g.cont_lvl == pwm_aq_pkg::ACT_HIGH);
        end else if (g.force_en && g.os_go) begin
            if (g.os_lvl == pwm_aq_pkg::ACT_LOW) begin
                s_d.out = 1'b0;
            end else if (g.os_lvl == pwm_aq_pkg::ACT_HIGH) begin
                s_d.out = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign g.out = s_q.out;
    assign g.cont_active = s_q.cont_active;

endmodule : pwm_out_resolver

// file: src/pwm_action_qualifier.sv
// Purpose: Action qualifier of a PWM operator with AXI4-Lite registers.
// Assumes: Timer inputs and event pulses come from logic on aclk.
// Notes: Address bits above the low eight are ignored.
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
module pwm_action_qualifier #(
    parameter int CW = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [CW-1:0] timer_count,
    input wire logic [CW-1:0] timer_period,
    input wire logic timer_down,
    input wire logic timer_updown,
    input wire logic [2:0] fault_event,
    input wire logic sync_event,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic pwm_out_a,
    output logic pwm_out_b,
    output logic [2*pwm_aq_pkg::NUM_EV-1:0] event_pulse
);
    localparam int CFG_W = pwm_aq_pkg::CFG_W;
    localparam int NEV = pwm_aq_pkg::NUM_EV;

    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] upd_mode;
        logic glob_upd;
        logic [CW-1:0] cmp_a_sh;
        logic [CW-1:0] cmp_b_sh;
        logic [CW-1:0] cmp_a;
        logic [CW-1:0] cmp_b;
        logic [CFG_W-1:0] act_a_sh;
        logic [CFG_W-1:0] act_b_sh;
        logic [CFG_W-1:0] act_a;
        logic [CFG_W-1:0] act_b;
        logic [1:0] t0_sel;
        logic [1:0] t1_sel;
        logic [pwm_aq_pkg::FRC_W-1:0] force_cfg;
        logic os_go_a;
        logic os_go_b;
        logic [2*NEV-1:0] event_pulse;
    } state_s;

    state_s s_q;
    state_s s_d;

    pwm_gen_if gen_a ();
    pwm_gen_if gen_b ();

    logic cnt_zero;
    logic cnt_per;
    logic hit_a;
    logic hit_b;
    logic trig_zero;
    logic trig_one;
    logic upd_now;
    logic [NEV-1:0] ev;
    logic [31:0] rd_word;
    logic rd_ok;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = data[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic pick_src(
        input logic [1:0] sel,
        input logic [2:0] fault,
        input logic sync
    );
        // Sources are free of any trip setting of the fault handler
        return (sel == 2'h3) ? sync : fault[sel];
    endfunction : pick_src

    // ------------------------------------------------------------
    // Event generation
    // ------------------------------------------------------------
    always_comb begin
        cnt_zero = (timer_count == '0);
        cnt_per = (timer_count == timer_period);
        // Compare beyond period can never be reached
        hit_a = (timer_count == s_q.cmp_a)
            && (s_q.cmp_a <= timer_period);
        hit_b = (timer_count == s_q.cmp_b)
            && (s_q.cmp_b <= timer_period);
        trig_zero = pick_src(s_q.t0_sel, fault_event, sync_event);
        trig_one = pick_src(s_q.t1_sel, fault_event, sync_event);
        ev = '0;
        ev[pwm_aq_pkg::EV_ZERO] = cnt_zero;
        ev[pwm_aq_pkg::EV_PERIOD] = cnt_per;
        ev[pwm_aq_pkg::EV_A] = hit_a;
        ev[pwm_aq_pkg::EV_B] = hit_b;
        ev[pwm_aq_pkg::EV_T0] = trig_zero;
        ev[pwm_aq_pkg::EV_T1] = trig_one;
        // Turnaround points only exist in one direction here
        if (timer_updown && !timer_down) begin
            ev[pwm_aq_pkg::EV_PERIOD] = 1'b0;
        end
        if (timer_updown && timer_down) begin
            ev[pwm_aq_pkg::EV_ZERO] = 1'b0;
        end
        // Count-up wraps period then zero on successive ticks, so
        // the two never share a cycle unless the period is zero
        if (!timer_updown && cnt_zero && cnt_per) begin
            ev[pwm_aq_pkg::EV_ZERO] = !timer_down;
            ev[pwm_aq_pkg::EV_PERIOD] = timer_down;
        end
    end

    // ------------------------------------------------------------
    // Shadow transfer moment
    // ------------------------------------------------------------
    always_comb begin
        unique case (pwm_aq_pkg::upd_e'(s_q.upd_mode))
            pwm_aq_pkg::UPD_ZERO: upd_now = cnt_zero;
            pwm_aq_pkg::UPD_PERIOD: upd_now = cnt_per;
            pwm_aq_pkg::UPD_SYNC: upd_now = sync_event;
            pwm_aq_pkg::UPD_NOW: upd_now = 1'b1;
        endcase
        upd_now = upd_now || s_q.glob_upd;
    end

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    always_comb begin
        rd_word = pwm_aq_pkg::RST_WORD;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            pwm_aq_pkg::ADDR_CTRL:
                rd_word[pwm_aq_pkg::CTRL_UPD_MODE +: 2] = s_q.upd_mode;
            pwm_aq_pkg::ADDR_CMP_A: rd_word[CW-1:0] = s_q.cmp_a_sh;
            pwm_aq_pkg::ADDR_CMP_B: rd_word[CW-1:0] = s_q.cmp_b_sh;
            pwm_aq_pkg::ADDR_ACT_A: rd_word[CFG_W-1:0] = s_q.act_a_sh;
            pwm_aq_pkg::ADDR_ACT_B: rd_word[CFG_W-1:0] = s_q.act_b_sh;
            pwm_aq_pkg::ADDR_TRIG_SEL: begin
                rd_word[pwm_aq_pkg::TSEL_T0 +: 2] = s_q.t0_sel;
                rd_word[pwm_aq_pkg::TSEL_T1 +: 2] = s_q.t1_sel;
            end
            pwm_aq_pkg::ADDR_FORCE:
                rd_word[pwm_aq_pkg::FRC_W-1:0] = s_q.force_cfg;
            pwm_aq_pkg::ADDR_STATUS: begin
                rd_word[pwm_aq_pkg::ST_OUT_A] = gen_a.out;
                rd_word[pwm_aq_pkg::ST_OUT_B] = gen_b.out;
                rd_word[pwm_aq_pkg::ST_DIR] = timer_down;
                rd_word[pwm_aq_pkg::ST_CONT_A] = gen_a.cont_active;
                rd_word[pwm_aq_pkg::ST_CONT_B] = gen_b.cont_active;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Bus slave and register file
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] wv;
        wv = pwm_aq_pkg::RST_WORD;
        s_d = s_q;
        s_d.glob_upd = 1'b0;
        s_d.os_go_a = 1'b0;
        s_d.os_go_b = 1'b0;

        // Active copies follow shadows only at the chosen moment
        if (upd_now) begin
            s_d.cmp_a = s_q.cmp_a_sh;
            s_d.cmp_b = s_q.cmp_b_sh;
            s_d.act_a = s_q.act_a_sh;
            s_d.act_b = s_q.act_b_sh;
        end

        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_have = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_have = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = pwm_aq_pkg::RESP_OKAY;
            unique case (s_q.awaddr)
                pwm_aq_pkg::ADDR_CTRL: begin
                    wv = merge({30'h0, s_q.upd_mode}, s_q.wdata, s_q.wstrb);
                    s_d.upd_mode = wv[pwm_aq_pkg::CTRL_UPD_MODE +: 2];
                    s_d.glob_upd = wv[pwm_aq_pkg::CTRL_GLOBAL_UPD];
                end
                pwm_aq_pkg::ADDR_CMP_A: begin
                    wv = merge(32'(s_q.cmp_a_sh), s_q.wdata, s_q.wstrb);
                    s_d.cmp_a_sh = wv[CW-1:0];
                end
                pwm_aq_pkg::ADDR_CMP_B: begin
                    wv = merge(32'(s_q.cmp_b_sh), s_q.wdata, s_q.wstrb);
                    s_d.cmp_b_sh = wv[CW-1:0];
                end
                pwm_aq_pkg::ADDR_ACT_A: begin
                    wv = merge(32'(s_q.act_a_sh), s_q.wdata, s_q.wstrb);
                    s_d.act_a_sh = wv[CFG_W-1:0];
                end
                pwm_aq_pkg::ADDR_ACT_B: begin
                    wv = merge(32'(s_q.act_b_sh), s_q.wdata, s_q.wstrb);
                    s_d.act_b_sh = wv[CFG_W-1:0];
                end
                pwm_aq_pkg::ADDR_TRIG_SEL: begin
                    wv = merge(rd_word_tsel(s_q.t0_sel, s_q.t1_sel),
                        s_q.wdata, s_q.wstrb);
                    s_d.t0_sel = wv[pwm_aq_pkg::TSEL_T0 +: 2];
                    s_d.t1_sel = wv[pwm_aq_pkg::TSEL_T1 +: 2];
                end
                pwm_aq_pkg::ADDR_FORCE: begin
                    wv = merge(32'(s_q.force_cfg), s_q.wdata, s_q.wstrb);
                    // Go bits act once and always read back as zero
                    s_d.os_go_a = wv[pwm_aq_pkg::FRC_OS_GO];
                    s_d.os_go_b =
                        wv[pwm_aq_pkg::FRC_B_BASE + pwm_aq_pkg::FRC_OS_GO];
                    wv[pwm_aq_pkg::FRC_OS_GO] = 1'b0;
                    wv[pwm_aq_pkg::FRC_B_BASE + pwm_aq_pkg::FRC_OS_GO] = 1'b0;
                    s_d.force_cfg = wv[pwm_aq_pkg::FRC_W-1:0];
                end
                pwm_aq_pkg::ADDR_STATUS: ;
                default: s_d.bresp = pwm_aq_pkg::RESP_SLVERR;
            endcase
        end
        s_d.awready = !s_d.aw_have && !s_d.bvalid;
        s_d.wready = !s_d.w_have && !s_d.bvalid;

        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_word;
            s_d.rresp = rd_ok ? pwm_aq_pkg::RESP_OKAY
                              : pwm_aq_pkg::RESP_SLVERR;
        end
        s_d.arready = !s_d.rvalid;

        // Events leave even when every action holds, for interrupts
        s_d.event_pulse = timer_down ? {ev, {NEV{1'b0}}}
                                     : {{NEV{1'b0}}, ev};
    end

    function automatic logic [31:0] rd_word_tsel(
        input logic [1:0] t0,
        input logic [1:0] t1
    );
        logic [31:0] r;
        r = pwm_aq_pkg::RST_WORD;
        r[pwm_aq_pkg::TSEL_T0 +: 2] = t0;
        r[pwm_aq_pkg::TSEL_T1 +: 2] = t1;
        return r;
    endfunction : rd_word_tsel

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Output resolvers
    // ------------------------------------------------------------
    assign gen_a.dir = timer_down;
    assign gen_a.ev = ev;
    assign gen_a.cfg = s_q.act_a;
    assign gen_a.force_en = s_q.force_cfg[pwm_aq_pkg::FRC_EN];
    assign gen_a.os_lvl = s_q.force_cfg[pwm_aq_pkg::FRC_OS_LVL +: 2];
    assign gen_a.os_go = s_q.os_go_a;
    assign gen_a.cont_lvl = s_q.force_cfg[pwm_aq_pkg::FRC_CONT_LVL +: 2];
    assign gen_a.cont_sel = s_q.force_cfg[pwm_aq_pkg::FRC_CONT_SEL +: 2];

    assign gen_b.dir = timer_down;
    assign gen_b.ev = ev;
    assign gen_b.cfg = s_q.act_b;
    assign gen_b.force_en =
        s_q.force_cfg[pwm_aq_pkg::FRC_B_BASE + pwm_aq_pkg::FRC_EN];
    assign gen_b.os_lvl =
        s_q.force_cfg[pwm_aq_pkg::FRC_B_BASE + pwm_aq_pkg::FRC_OS_LVL +: 2];
    assign gen_b.os_go = s_q.os_go_b;
    assign gen_b.cont_lvl =
        s_q.force_cfg[pwm_aq_pkg::FRC_B_BASE + pwm_aq_pkg::FRC_CONT_LVL +: 2];
    assign gen_b.cont_sel =
        s_q.force_cfg[pwm_aq_pkg::FRC_B_BASE + pwm_aq_pkg::FRC_CONT_SEL +: 2];

    pwm_out_resolver u_res_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .g(gen_a.gen)
    );

    pwm_out_resolver u_res_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .g(gen_b.gen)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign pwm_out_a = gen_a.out;
    assign pwm_out_b = gen_b.out;
    assign event_pulse = s_q.event_pulse;

endmodule : pwm_action_qualifier

// file: tb/pwm_timer_model.sv
// Purpose: Stand-in for the PWM timer that feeds the qualifier.
// Assumes: One tick per aclk; period of at least two.
// Notes: Up-down mode turns round at period and at zero.
module pwm_timer_model #(
    parameter int CW = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [CW-1:0] timer_period,
    input wire logic timer_updown,
    output logic [CW-1:0] timer_count,
    output logic timer_down
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_count <= '0;
            timer_down <= 1'h0;
        end else if (!timer_updown) begin
            timer_down <= 1'h0;
            timer_count <= (timer_count >= timer_period) ? '0
                                                         : timer_count + 1'h1;
        end else if (!timer_down) begin
            timer_count <= timer_count + 1'h1;
            timer_down <= (timer_count + 1'h1 >= timer_period);
        end else begin
            timer_count <= timer_count - 1'h1;
            timer_down <= (timer_count != 1);
        end
    end
endmodule : pwm_timer_model

// file: tb/pwm_aq_monitor.sv
// Purpose: Port checks of the PWM action qualifier.
// Assumes: Event pulses show one edge after their cause.
// Notes: Bound from the testbench.
module pwm_aq_monitor #(
    parameter int CW = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [CW-1:0] timer_count,
    input wire logic [CW-1:0] timer_period,
    input wire logic timer_down,
    input wire logic timer_updown,
    input wire logic [2:0] fault_event,
    input wire logic sync_event,
    input wire logic pwm_out_a,
    input wire logic [11:0] event_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic [11:0] e = event_pulse;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    no_up_period_a:
        assert property (e[1] |-> !$past(timer_updown))
        else $error("up period in up-down mode");
    no_down_zero_a:
        assert property (e[6] |-> !$past(timer_updown))
        else $error("down zero in up-down mode");
    up_zero_cause_a:
        assert property (e[0] |-> $past(timer_count) == 0 && !$past(timer_down))
        else $error("up zero without cause");
    down_period_cause_a:
        assert property (e[7] |-> $past(timer_down) &&
            $past(timer_count) == $past(timer_period))
        else $error("down period without cause");
    up_ends_apart_a:
        assert property (!(e[0] && e[1])) else $error("up zero with period");
    down_ends_apart_a:
        assert property (!(e[6] && e[7])) else $error("down zero with period");
    cmp_in_range_a:
        assert property (e[2] || e[8] |-> $past(timer_count) <= $past(timer_period))
        else $error("compare beyond period");
    trig_has_source_a:
        assert property (e[4] || e[10] |-> $past(fault_event) != 0 || $past(sync_event))
        else $error("trigger without source");
    cover property (e[2] ##[1:40] e[8]);
    cover property ($rose(pwm_out_a));
    cover property (e[4]);
endmodule : pwm_aq_monitor

// file: tb/testbench.sv
// Purpose: Self-checking bench of the PWM action qualifier.
// Assumes: Timer model period input of ten.
// Notes: Registers reached over AXI4-Lite tasks.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'h0, aresetn = 1'h0, timer_updown = 1'h0, sync_event = 1'h0;
    logic timer_down, pwm_out_a, pwm_out_b, s_axi_bvalid, s_axi_rvalid;
    logic s_axi_awready, s_axi_wready, s_axi_arready;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [15:0] timer_count, timer_period = 16'h000A;
    logic [2:0] fault_event = 3'h0, s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [11:0] event_pulse;
    int fails = 0, n_compared = 0, cycles = 0;
    always #50 aclk = ~aclk;
    pwm_timer_model timer (.*);
    pwm_action_qualifier DUT (.*);
    always @(posedge aclk) if (++cycles > 3000) begin
        fails++;
        give_verdict();
    end
    task automatic give_verdict();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, d);
        chk(32'(s_axi_rresp), 32'(r));
    endtask : rchk
    // Skips two cycles so a fresh action setup is already active
    task automatic evchk(input int i, input bit b, input logic v);
        int n;
        repeat (2) @(negedge aclk);
        for (n = 0; n < 40 && event_pulse[i] !== 1'h1; n++) @(negedge aclk);
        chk(32'({event_pulse[i], b ? pwm_out_b : pwm_out_a}), 32'({1'h1, v}));
    endtask : evchk
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        rchk(8'h0C, 32'h0, 2'h0);
        rchk(8'h20, 32'h0, 2'h2);
        wr(8'h00, 32'h3);
        wr(8'h04, 32'h4);
        rchk(8'h04, 32'h4, 2'h0);
        $display("register test done");
        timer_updown <= 1'h1;
        wr(8'h0C, 32'h1_0020);
        evchk(2, 1'h0, 1'h1);
        evchk(8, 1'h0, 1'h0);
        $display("symmetric test done");
        wr(8'h08, 32'h4);
        wr(8'h0C, 32'h9_0060);
        evchk(8, 1'h0, 1'h1);
        evchk(2, 1'h0, 1'h0);
        $display("priority test done");
        wr(8'h18, 32'h0D);
        repeat (3) @(negedge aclk);
        chk(32'(pwm_out_a), 32'h1);
        evchk(2, 1'h0, 1'h0);
        wr(8'h10, 32'h1_0020);
        wr(8'h18, 32'h1100);
        evchk(2, 1'h1, 1'h0);
        wr(8'h18, 32'h0100);
        evchk(2, 1'h1, 1'h1);
        $display("force test done");
        wr(8'h14, 32'h3);
        @(posedge aclk) sync_event <= 1'h1;
        @(posedge aclk) sync_event <= 1'h0;
        @(negedge aclk);
        chk(32'(event_pulse[4] | event_pulse[10]), 32'h1);
        $display("trigger test done");
        give_verdict();
    end
endmodule : testbench
bind pwm_action_qualifier pwm_aq_monitor #(.CW(CW)) mon (.*);
